// ===== logic/mpc_pkg.sv
package mpc_pkg;

  // ---------------------------------------------------------------
  // register map
  // ---------------------------------------------------------------
  localparam logic [3:0] MPC_ADDR_CTRL_ONE  = 4'h0;
  localparam logic [3:0] MPC_ADDR_CTRL_TWO  = 4'h1;
  localparam logic [3:0] MPC_ADDR_PRESET    = 4'h2;
  localparam logic [3:0] MPC_ADDR_FLAGS     = 4'h3;
  localparam logic [3:0] MPC_ADDR_STATUS    = 4'h4;

  localparam logic [7:0] MPC_CTRL_ONE_RST   = 8'h00;
  localparam logic [7:0] MPC_CTRL_TWO_RST   = 8'h00;
  localparam logic [7:0] MPC_PRESET_RST     = 8'h00;
  localparam logic [7:0] MPC_FLAGS_RST      = 8'h00;
  localparam logic [7:0] MPC_CTRL_TWO_MASK  = 8'h7F;
  localparam logic [7:0] MPC_PRESET_MASK    = 8'h3F;
  localparam logic [7:0] MPC_FLAGS_MASK     = 8'h01;
  // gate patterns: all sides off, low sides on
  localparam logic [5:0] MPC_GATE_OFF       = 6'h00;
  localparam logic [5:0] MPC_GATE_BRAKE     = 6'h2A;

  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam int MPC_CLK_MHZ         = 125;
  localparam int MPC_FILTER_CLOCKS   = 2;

  // ---------------------------------------------------------------
  // field layouts
  // ---------------------------------------------------------------
  typedef struct packed {
    logic sw_protection_data;
    logic sw_protection_enable;
    logic stall_overflow_hw_enable;
    logic stall_compare_hw_enable;
    logic overcurrent_hw_enable;
    logic limit_hw_enable;
    logic override_sw_trigger;
    logic override_hw_enable;
  } mpc_ctrl_one_s;

  typedef struct packed {
    logic unused7;
    logic override_source_select;
    logic cycle_by_cycle_enable;
    logic sw_protection_mode_select;
    logic limit_restart_select;
    logic overcurrent_mode_select;
    logic stall_compare_mode_select;
    logic stall_overflow_mode_select;
  } mpc_ctrl_two_s;

  // gate pairs: a, b, c, each high and low side
  typedef struct packed {
    logic c_low;
    logic c_high;
    logic b_low;
    logic b_high;
    logic a_low;
    logic a_high;
  } mpc_gate_s;

  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [3:0] addr;
    logic [7:0] wdata;
  } mpc_bus_s;

  typedef enum logic [1:0] {
    MPC_LIM_RUN  = 2'b00,
    MPC_LIM_OFF  = 2'b01,
    MPC_LIM_WAIT = 2'b10
  } mpc_lim_e;

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  // pause-or-fault latch: trigger sets, fault clears on condition gone
  function automatic logic mpc_src_next(input logic held, input logic trig,
                                        input logic pause, input logic sw_rel);
    logic n;
    n = held;
    if (pause) begin
      if (sw_rel) begin
        n = 1'b0;
      end
    end else begin
      n = 1'b0;
    end
    if (trig) begin
      n = 1'b1;
    end
    return n;
  endfunction

endpackage

// ===== logic/mpc_protect.sv
// Contract
// - protection forces brake or free-run drive
// - fault mode releases when trigger clears
// - pause mode holds until software release
// - override drives preset outputs immediately
// - override released only by software
// - comparator filtered over two system clocks
// - limit acts only when enabled, channel
// - limit restart immediate or next period
// - overcurrent enable gates; mode bit selects
// - hardware override latches filtered pulse
// - enable low-high write clears override
// - software override bit sets and clears
// - compare stall enabled, pause mode
// - overflow stall enabled, pause mode
// - software data triggers/releases per mode
// - enable 1-0-1 releases software protection
// - stall from capture timer events
// - software mode select fault or pause
// - cycle-by-cycle off, back next period
// - override source filtered or cmp1 edge
//
// Local design decisions: the address map and the address-and-strobe port.
`timescale 1ns/1ps
module mpc_protect
  import mpc_pkg::*;
(
  // clock and reset
  input  wire logic            clk_sys,
  input  wire logic            rst,
  // register port
  input  wire logic [3:0]      reg_addr,
  input  wire logic [7:0]      reg_wdata,
  input  wire logic            reg_wr,
  input  wire logic            reg_rd,
  output logic [7:0]           reg_rdata,
  // analog and timer events (asynchronous)
  input  wire logic            overcurrent_cmp,
  input  wire logic            cmp1_out,
  input  wire logic            current_limit_event,
  input  wire logic            adc_selects_amp,
  // same-domain inputs
  input  wire logic            capture_compare_event,
  input  wire logic            capture_overflow_event,
  input  wire logic            pwm_period_start,
  input  wire mpc_pkg::mpc_gate_s drive_in,
  // outputs
  output mpc_pkg::mpc_gate_s   drive_out,
  output logic                 protect_active,
  output logic                 fast_overcurrent_override,
  output logic                 filtered_overcurrent_pulse
);
  import mpc_pkg::*;

  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  mpc_ctrl_one_s ctrl1_q;
  mpc_ctrl_two_s ctrl2_q;
  mpc_gate_s     preset_q;
  logic          brake_freerun_select_q;
  mpc_bus_s      bus;

  assign bus = '{wr: reg_wr, rd: reg_rd, addr: reg_addr, wdata: reg_wdata};

  wire wr_c1 = bus.wr && (bus.addr == MPC_ADDR_CTRL_ONE);
  wire wr_c2 = bus.wr && (bus.addr == MPC_ADDR_CTRL_TWO);
  wire wr_ps = bus.wr && (bus.addr == MPC_ADDR_PRESET);
  wire wr_fl = bus.wr && (bus.addr == MPC_ADDR_FLAGS);
  mpc_ctrl_one_s c1_new;
  mpc_ctrl_two_s c2_new;
  mpc_gate_s     ps_new;
  assign c1_new = mpc_ctrl_one_s'(bus.wdata);
  // unimplemented bits forced to zero on write
  assign c2_new = mpc_ctrl_two_s'(bus.wdata & MPC_CTRL_TWO_MASK);
  assign ps_new = mpc_gate_s'(bus.wdata[5:0]);

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      ctrl1_q <= mpc_ctrl_one_s'(MPC_CTRL_ONE_RST);
    end else if (wr_c1) begin
      ctrl1_q <= c1_new;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      ctrl2_q <= mpc_ctrl_two_s'(MPC_CTRL_TWO_RST);
    end else if (wr_c2) begin
      ctrl2_q <= c2_new;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      preset_q <= mpc_gate_s'(MPC_PRESET_RST[5:0]);
    end else if (wr_ps) begin
      preset_q <= ps_new;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      brake_freerun_select_q <= MPC_FLAGS_RST[0];
    end else if (wr_fl) begin
      brake_freerun_select_q <= bus.wdata[0];
    end
  end

  // ---------------------------------------------------------------
  // input synchronisers
  // ---------------------------------------------------------------
  logic [1:0] oc_sync_q;
  logic [1:0] cmp1_sync_q;
  logic [1:0] lim_sync_q;
  logic [1:0] chan_sync_q;

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      oc_sync_q   <= 2'h0;
      cmp1_sync_q <= 2'h0;
      lim_sync_q  <= 2'h0;
      chan_sync_q <= 2'h0;
    end else begin
      oc_sync_q   <= {oc_sync_q[0], overcurrent_cmp};
      cmp1_sync_q <= {cmp1_sync_q[0], cmp1_out};
      lim_sync_q  <= {lim_sync_q[0], current_limit_event};
      chan_sync_q <= {chan_sync_q[0], adc_selects_amp};
    end
  end

  wire oc_s   = oc_sync_q[1];
  wire cmp1_s = cmp1_sync_q[1];
  wire lim_s  = lim_sync_q[1];
  wire chan_s = chan_sync_q[1];

  // ---------------------------------------------------------------
  // overcurrent filter
  // ---------------------------------------------------------------
  // two-clock filter
  logic [MPC_FILTER_CLOCKS-1:0] filt_q;
  logic                         filt_lvl_q;
  logic                         cmp1_d1_q;

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      filt_q     <= '0;
      filt_lvl_q <= 1'b0;
      cmp1_d1_q  <= 1'b0;
    end else begin
      filt_q    <= {filt_q[MPC_FILTER_CLOCKS-2:0], oc_s};
      cmp1_d1_q <= cmp1_s;
      if (&filt_q) filt_lvl_q <= 1'b1;
      else if (~|filt_q) filt_lvl_q <= 1'b0;
    end
  end

  // filtered level, pulse on its rising edge
  wire oc_level = filt_lvl_q;
  logic oc_level_d1_q;
  always_ff @(posedge clk_sys) begin
    if (rst) oc_level_d1_q <= 1'b0;
    else     oc_level_d1_q <= oc_level;
  end
  assign filtered_overcurrent_pulse = oc_level & ~oc_level_d1_q;

  // ---------------------------------------------------------------
  // software edge detection
  // ---------------------------------------------------------------
  // enable rising write
  wire hw_ovr_rise = wr_c1 && c1_new.override_hw_enable && !ctrl1_q.override_hw_enable;
  wire sw_en_rise  = wr_c1 && c1_new.sw_protection_enable && !ctrl1_q.sw_protection_enable;
  // enable seen high once, so the very first enable is no release
  logic sw_armed_q;
  wire  sw_toggle  = sw_en_rise && sw_armed_q;

  // ---------------------------------------------------------------
  // fast overcurrent override
  // ---------------------------------------------------------------
  // source select
  wire ovr_src = ctrl2_q.override_source_select ? (cmp1_s & ~cmp1_d1_q)
                                                : filtered_overcurrent_pulse;
  logic ovr_hw_q;
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      ovr_hw_q <= 1'b0;
    end else if (ctrl1_q.override_hw_enable && ovr_src) begin
      ovr_hw_q <= 1'b1;
    end else if (hw_ovr_rise || !ctrl1_q.override_hw_enable) begin
      ovr_hw_q <= ovr_hw_q & ~hw_ovr_rise;
    end
  end
  assign fast_overcurrent_override = ovr_hw_q | ctrl1_q.override_sw_trigger;

  // ---------------------------------------------------------------
  // general protection sources
  // ---------------------------------------------------------------
  logic oc_held_q;
  logic cmp_held_q;
  logic ovf_held_q;
  logic sw_held_q;

  wire oc_trig  = ctrl1_q.overcurrent_hw_enable & oc_level;
  wire cmp_trig = ctrl1_q.stall_compare_hw_enable & capture_compare_event;
  wire ovf_trig = ctrl1_q.stall_overflow_hw_enable & capture_overflow_event;
  wire sw_pause = ctrl2_q.sw_protection_mode_select;
  // trigger on a write that sets data, unless it is the release toggle
  wire sw_trig  = wr_c1 && c1_new.sw_protection_enable &&
                  c1_new.sw_protection_data && !sw_toggle;
  // software release: data cleared or enable toggled 1-0-1
  wire sw_rel   = (wr_c1 && !c1_new.sw_protection_data) || sw_toggle;

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      oc_held_q  <= 1'b0;
      cmp_held_q <= 1'b0;
      ovf_held_q <= 1'b0;
      sw_held_q  <= 1'b0;
      sw_armed_q <= 1'b0;
    end else begin
      oc_held_q  <= mpc_src_next(oc_held_q, oc_trig,
                                 ctrl2_q.overcurrent_mode_select, sw_rel);
      cmp_held_q <= mpc_src_next(cmp_held_q, cmp_trig,
                                 ctrl2_q.stall_compare_mode_select, sw_rel);
      ovf_held_q <= mpc_src_next(ovf_held_q, ovf_trig,
                                 ctrl2_q.stall_overflow_mode_select, sw_rel);
      sw_held_q  <= mpc_src_next(sw_held_q, sw_pause & sw_trig & ~sw_rel,
                                 sw_pause, sw_rel);
      sw_armed_q <= sw_armed_q | ctrl1_q.sw_protection_enable;
    end
  end

  // fault mode: software release masks held fault sources
  logic fault_mask_q;
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      fault_mask_q <= 1'b0;
    end else if (ctrl1_q.sw_protection_enable && !sw_pause && ctrl1_q.sw_protection_data) begin
      fault_mask_q <= 1'b0;
    end else if (ctrl1_q.sw_protection_enable && !sw_pause && sw_rel) begin
      fault_mask_q <= 1'b1;
    end else if (!(oc_held_q | cmp_held_q | ovf_held_q)) begin
      fault_mask_q <= 1'b0;
    end
  end

  assign protect_active = ((oc_held_q | cmp_held_q | ovf_held_q) & ~fault_mask_q) | sw_held_q;

  // ---------------------------------------------------------------
  // current limit and cycle-by-cycle gating
  // ---------------------------------------------------------------
  // limit enable and channel
  wire lim_act = ctrl1_q.limit_hw_enable & chan_s & lim_s;
  mpc_lim_e lim_q;
  mpc_lim_e lim_d;
  always_comb begin
    lim_d = lim_q;
    case (lim_q)
      MPC_LIM_RUN:  if (lim_act) lim_d = MPC_LIM_OFF;
      MPC_LIM_OFF:  if (!lim_act) lim_d = ctrl2_q.limit_restart_select ? MPC_LIM_WAIT
                                                                      : MPC_LIM_RUN;
      MPC_LIM_WAIT: if (lim_act) lim_d = MPC_LIM_OFF;
                    else if (pwm_period_start) lim_d = MPC_LIM_RUN;
      default:      lim_d = MPC_LIM_RUN;
    endcase
  end

  logic cyc_off_q;
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      lim_q     <= MPC_LIM_RUN;
      cyc_off_q <= 1'b0;
    end else begin
      lim_q <= lim_d;
      if (ctrl2_q.cycle_by_cycle_enable && oc_level) cyc_off_q <= 1'b1;
      else if (pwm_period_start || !ctrl2_q.cycle_by_cycle_enable) cyc_off_q <= 1'b0;
    end
  end
  wire pwm_off = (lim_q != MPC_LIM_RUN) | cyc_off_q |
                 (ctrl2_q.cycle_by_cycle_enable & oc_level);

  // ---------------------------------------------------------------
  // output selection
  // ---------------------------------------------------------------
  // brake or free-run
  mpc_gate_s prot_drive;
  assign prot_drive = brake_freerun_select_q ? mpc_gate_s'(MPC_GATE_OFF)
                                             : mpc_gate_s'(MPC_GATE_BRAKE);
  mpc_gate_s drive_d;
  assign drive_d = fast_overcurrent_override ? preset_q :
                   protect_active            ? prot_drive :
                   pwm_off                   ? mpc_gate_s'(MPC_GATE_OFF) : drive_in;
  always_ff @(posedge clk_sys) begin
    if (rst) drive_out <= mpc_gate_s'(MPC_GATE_OFF);
    else     drive_out <= drive_d;
  end

  // ---------------------------------------------------------------
  // read back
  // ---------------------------------------------------------------
  wire [7:0] status_w = {4'h0, pwm_off, oc_level, fast_overcurrent_override, protect_active};
  logic [7:0] rd_mux;
  always_comb begin
    rd_mux = 8'h00;
    if (bus.addr == MPC_ADDR_CTRL_ONE) begin
      rd_mux = 8'(ctrl1_q);
    end else if (bus.addr == MPC_ADDR_CTRL_TWO) begin
      rd_mux = 8'(ctrl2_q);
    end else if (bus.addr == MPC_ADDR_PRESET) begin
      rd_mux = {2'h0, preset_q};
    end else if (bus.addr == MPC_ADDR_FLAGS) begin
      rd_mux = {7'h00, brake_freerun_select_q};
    end else if (bus.addr == MPC_ADDR_STATUS) begin
      rd_mux = status_w;
    end
  end
  always_ff @(posedge clk_sys) begin
    if (rst)         reg_rdata <= 8'h00;
    else if (bus.rd) reg_rdata <= rd_mux;
    else             reg_rdata <= 8'h00;
  end

endmodule // mpc_protect

// ===== verif/mpc_protect_chk.sv
`timescale 1ns/1ps
module mpc_protect_chk (
  // clock and reset
  input wire logic              clk_sys,
  input wire logic              rst,
  // register port
  input wire logic [3:0]        reg_addr,
  input wire logic [7:0]        reg_wdata,
  input wire logic              reg_wr,
  input wire logic              reg_rd,
  input wire logic [7:0]        reg_rdata,
  // protection
  input wire logic              overcurrent_cmp,
  input wire mpc_pkg::mpc_gate_s drive_in,
  input wire mpc_pkg::mpc_gate_s drive_out,
  input wire logic              protect_active,
  input wire logic              fast_overcurrent_override,
  input wire logic              filtered_overcurrent_pulse
);
  import mpc_pkg::*;
  // -------------------------------------------------------------
  // register mirror
  // -------------------------------------------------------------
  logic [7:0] c1_q, c2_q, pre_q;
  logic       fl_q, w1, ovr, pls;
  assign w1  = reg_wr && reg_addr == MPC_ADDR_CTRL_ONE;
  assign ovr = fast_overcurrent_override;
  assign pls = filtered_overcurrent_pulse;
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      {c1_q, c2_q, pre_q, fl_q} <= 25'h0000000;
    end else if (reg_wr) begin
      case (reg_addr)
        MPC_ADDR_CTRL_ONE: c1_q <= reg_wdata;
        MPC_ADDR_CTRL_TWO: c2_q <= reg_wdata;
        MPC_ADDR_PRESET:   pre_q <= reg_wdata & MPC_PRESET_MASK;
        MPC_ADDR_FLAGS:    fl_q <= reg_wdata[0];
        default:           fl_q <= fl_q;
      endcase
    end
  end
  // -------------------------------------------------------------
  // assertions
  // -------------------------------------------------------------
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (rst);
  sequence s_glitch;
    !overcurrent_cmp [*6] ##1 overcurrent_cmp ##1 !overcurrent_cmp;
  endsequence
  a_forced_drive: assert property (
    protect_active && !ovr |=> drive_out == ($past(fl_q) ? 6'h00 : 6'h2A))
    else $error("forced drive wrong");
  a_normal_drive: assert property (
    !protect_active && !ovr && !c1_q[2] && !c2_q[5] |=> drive_out == $past(drive_in))
    else $error("normal drive not passed");
  a_override_hold: assert property (ovr && !w1 |=> ovr)
    else $error("override dropped alone");
  a_pulse_once: assert property (pls |=> !pls)
    else $error("filtered pulse too long");
  a_glitch_drop: assert property (s_glitch |=> !pls [*5])
    else $error("glitch passed filter");
  a_preset_out: assert property (ovr |=> drive_out == $past(pre_q[5:0]))
    else $error("preset not driven");
  a_sw_override: assert property (w1 && reg_wdata[1] |=> ovr)
    else $error("sw override not set");
  a_hw_latch: assert property (
    pls && c1_q[0] && c1_q[3] && !c2_q[6] |=> ovr)
    else $error("hw override not latched");
  a_read_idle: assert property (!reg_rd |=> reg_rdata == 8'h00)
    else $error("read data outside slot");
endmodule // mpc_protect_chk

bind mpc_protect mpc_protect_chk u_chk (.*);

// ===== verif/mpc_gate_model.sv
`timescale 1ns/1ps
module mpc_gate_model (
  // gate inputs
  input  wire mpc_pkg::mpc_gate_s gate,
  // pair states
  output logic                    braking,
  output logic                    coasting
);
  import mpc_pkg::*;
  assign braking  = gate == 6'h2A;
  assign coasting = gate == 6'h00;
endmodule // mpc_gate_model

// ===== verif/test_motor_protection_control.sv
`timescale 1ns/1ps
module test_motor_protection_control;
  import mpc_pkg::*;
  // -------------------------------------------------------------
  // signals
  // -------------------------------------------------------------
  typedef struct packed {logic [3:0] a; logic [7:0] w; logic [7:0] r;} mpc_row_s;
  logic       clk_sys, rst, reg_wr, reg_rd, overcurrent_cmp, cmp1_out;
  logic       current_limit_event, adc_selects_amp, capture_compare_event;
  logic       capture_overflow_event, pwm_period_start, protect_active;
  logic       fast_overcurrent_override, filtered_overcurrent_pulse, braking, coasting;
  logic [3:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata, v;
  mpc_gate_s  drive_in, drive_out;
  int         fail_count, n_tests, cycles;
  mpc_row_s   rows [8] = '{'{4'h1, 8'hFF, 8'h7F}, '{4'h2, 8'hFF, 8'h3F},
    '{4'h3, 8'hFF, 8'h01}, '{4'h7, 8'hFF, 8'h00}, '{4'h4, 8'hFF, 8'h00},
    '{4'h0, 8'h00, 8'h00}, '{4'h1, 8'h00, 8'h00}, '{4'h3, 8'h00, 8'h00}};
  mpc_protect uut (
    .clk_sys                    (clk_sys),
    .rst                        (rst),
    .reg_addr                   (reg_addr),
    .reg_wdata                  (reg_wdata),
    .reg_wr                     (reg_wr),
    .reg_rd                     (reg_rd),
    .reg_rdata                  (reg_rdata),
    .overcurrent_cmp            (overcurrent_cmp),
    .cmp1_out                   (cmp1_out),
    .current_limit_event        (current_limit_event),
    .adc_selects_amp            (adc_selects_amp),
    .capture_compare_event      (capture_compare_event),
    .capture_overflow_event     (capture_overflow_event),
    .pwm_period_start           (pwm_period_start),
    .drive_in                   (drive_in),
    .drive_out                  (drive_out),
    .protect_active             (protect_active),
    .fast_overcurrent_override  (fast_overcurrent_override),
    .filtered_overcurrent_pulse (filtered_overcurrent_pulse)
  );
  mpc_gate_model u_gate (.gate(drive_out), .braking(braking), .coasting(coasting));
  initial begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) begin
    if (rst) begin
      drive_in <= '0;
    end else begin
      drive_in <= mpc_gate_s'(drive_in + 6'h05);
    end
    cycles++;
    if (cycles == 5000) begin
      fail_count++;
      conclude();
    end
  end
  // -------------------------------------------------------------
  // tasks
  // -------------------------------------------------------------
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
    #1;
  endtask
  task automatic rd(input logic [3:0] a);
    @(posedge clk_sys);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1;
    v = reg_rdata;
  endtask
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    n_tests++;
    if (g !== e) begin
      fail_count++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic oc_burst(input int n);
    overcurrent_cmp <= 1'b1;
    cyc(n);
    overcurrent_cmp <= 1'b0;
    cyc(8);
  endtask
  task automatic conclude();
    if (fail_count == 0 && n_tests > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  // -------------------------------------------------------------
  // sequence
  // -------------------------------------------------------------
  initial begin
    {reg_wr, reg_rd, overcurrent_cmp, cmp1_out, current_limit_event} = 5'h00;
    {adc_selects_amp, capture_compare_event, capture_overflow_event} = 3'h0;
    {pwm_period_start, reg_addr, reg_wdata} = 13'h0000;
    rst = 1'b1;
    cyc(20);
    rst <= 1'b0;
    for (int i = 0; i < 5; i++) begin
      rd(i[3:0]);
      chk("reset value", 8'h00, v);
    end
    foreach (rows[i]) begin
      wr(rows[i].a, rows[i].w);
      rd(rows[i].a);
      chk("readback", rows[i].r, v);
    end
    wr(MPC_ADDR_CTRL_ONE, 8'hC0);
    chk("sw fault no trigger", 8'h00, protect_active);
    wr(MPC_ADDR_CTRL_TWO, 8'h10);
    wr(MPC_ADDR_CTRL_ONE, 8'hC0);
    cyc(2);
    chk("brake drive", 8'h2A, drive_out);
    chk("brake pairs", 8'h01, braking);
    wr(MPC_ADDR_FLAGS, 8'h01);
    cyc(10);
    chk("free-run pairs", 8'h01, coasting);
    chk("pause held", 8'h01, protect_active);
    wr(MPC_ADDR_CTRL_ONE, 8'h80);
    chk("toggle low holds", 8'h01, protect_active);
    wr(MPC_ADDR_CTRL_ONE, 8'hC0);
    chk("toggle release", 8'h00, protect_active);
    wr(MPC_ADDR_CTRL_ONE, 8'hC0);
    chk("retrigger", 8'h01, protect_active);
    wr(MPC_ADDR_CTRL_ONE, 8'h40);
    chk("sw release", 8'h00, protect_active);
    wr(MPC_ADDR_CTRL_TWO, 8'h00);
    wr(MPC_ADDR_CTRL_ONE, 8'h08);
    oc_burst(1);
    chk("glitch ignored", 8'h00, protect_active);
    overcurrent_cmp <= 1'b1;
    cyc(8);
    chk("fault set", 8'h01, protect_active);
    oc_burst(0);
    chk("fault cleared", 8'h00, protect_active);
    wr(MPC_ADDR_CTRL_TWO, 8'h04);
    oc_burst(4);
    chk("oc pause held", 8'h01, protect_active);
    wr(MPC_ADDR_CTRL_ONE, 8'h00);
    oc_burst(4);
    chk("oc disabled", 8'h00, protect_active);
    wr(MPC_ADDR_CTRL_TWO, 8'h03);
    for (int k = 0; k < 2; k++) begin
      {capture_overflow_event, capture_compare_event} <= 2'b01 << k;
      cyc(2);
      {capture_overflow_event, capture_compare_event} <= 2'b00;
      cyc(4);
      chk("stall disabled", 8'h00, protect_active);
      wr(MPC_ADDR_CTRL_ONE, 8'h10 << k);
      {capture_overflow_event, capture_compare_event} <= 2'b01 << k;
      cyc(2);
      {capture_overflow_event, capture_compare_event} <= 2'b00;
      cyc(6);
      chk("stall held", 8'h01, protect_active);
      wr(MPC_ADDR_CTRL_ONE, 8'h10 << k);
      chk("stall released", 8'h00, protect_active);
    end
    wr(MPC_ADDR_PRESET, 8'h15);
    for (int s = 0; s < 2; s++) begin
      wr(MPC_ADDR_CTRL_TWO, {1'b0, s[0], 6'h00});
      wr(MPC_ADDR_CTRL_ONE, 8'h08);
      wr(MPC_ADDR_CTRL_ONE, 8'h09);
      oc_burst(4);
      chk("hw override source", !s[0], fast_overcurrent_override);
      cmp1_out <= 1'b1;
      cyc(8);
      cmp1_out <= 1'b0;
      cyc(10);
      chk("override held", 8'h01, fast_overcurrent_override);
      chk("preset drive", 8'h15, drive_out);
      wr(MPC_ADDR_CTRL_ONE, 8'h08);
      wr(MPC_ADDR_CTRL_ONE, 8'h09);
      chk("override cleared", 8'h00, fast_overcurrent_override);
    end
    wr(MPC_ADDR_CTRL_ONE, 8'h02);
    cyc(1);
    chk("sw override drive", 8'h15, drive_out);
    wr(MPC_ADDR_CTRL_ONE, 8'h04);
    chk("sw override off", 8'h00, fast_overcurrent_override);
    current_limit_event <= 1'b1;
    cyc(8);
    rd(MPC_ADDR_STATUS);
    chk("limit channel gate", 8'h00, v[3]);
    adc_selects_amp <= 1'b1;
    for (int r = 0; r < 2; r++) begin
      wr(MPC_ADDR_CTRL_TWO, {4'h0, r[0], 3'h0});
      current_limit_event <= 1'b1;
      cyc(8);
      rd(MPC_ADDR_STATUS);
      chk("limit off", 8'h01, v[3]);
      current_limit_event <= 1'b0;
      cyc(8);
      rd(MPC_ADDR_STATUS);
      chk("restart wait", r[0], v[3]);
      pwm_period_start <= 1'b1;
      cyc(1);
      pwm_period_start <= 1'b0;
      rd(MPC_ADDR_STATUS);
      chk("restart period", 8'h00, v[3]);
    end
    wr(MPC_ADDR_CTRL_TWO, 8'h20);
    overcurrent_cmp <= 1'b1;
    cyc(8);
    rd(MPC_ADDR_STATUS);
    chk("cycle cutoff", 8'h01, v[3]);
    oc_burst(0);
    rd(MPC_ADDR_STATUS);
    chk("cycle hold", 8'h01, v[3]);
    pwm_period_start <= 1'b1;
    cyc(1);
    pwm_period_start <= 1'b0;
    rd(MPC_ADDR_STATUS);
    chk("cycle restart", 8'h00, v[3]);
    conclude();
  end
endmodule // test_motor_protection_control
